/* File: hdl/signal_monitor_peak_sync.sv */
// Signal monitor with peak detector, period counter and SYSREF alignment
// What this block does
// - Measurement window length equals a 24-bit period from three byte fields.
// - Period low byte resets to 0x80, a 128-cycle window.
// - Mode bit 0 aligns on every SYSREF edge; 1 only the next edge.
// - In next-edge mode the enable bit clears after the edge is used.
// - Enable bit 0 gates all SYSREF alignment off.
// - No alignment while the SYSREF receiver is disabled.
// - Control bit 1 enables the peak detector; resets disabled.
// - Reserved control bits read zero and ignore writes.
// - An 8-bit frame counter increments at each period expiry not swallowed by an alignment in the same cycle.
// - Self-clearing update bit copies the current result into status registers when result select is 001, else zero.
// - Status result is 20 bits over three byte registers.
// - Result select 001, the reset value, routes the peak to readback.
`include "sigmon_consts.svh"
module signal_monitor_peak_sync #(
   parameter int SAMPLE_W = 14
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Converter samples and timing input
   input wire logic signed [SAMPLE_W-1:0] sample,
   input wire logic sysref,
   // Status towards the framer
   output logic period_tick
);

   // Refuse sample widths that the 20-bit result cannot carry
   if (SAMPLE_W < 2 || SAMPLE_W > 20) begin : g_bad_width
      $error("SAMPLE_W must lie between 2 and 20");
   end

   // Control and status state
   logic sync_en_q;
   logic sync_mode_q;
   logic peak_en_q;
   logic [7:0] period0_q, period1_q, period2_q;
   logic [2:0] sel_q;
   logic sysref_rx_en_q;
   logic [23:0] cnt_q;
   logic [19:0] peak_q;
   logic [19:0] result_q;
   logic [19:0] status_q;
   logic [7:0] frame_q;
   logic sysref_q;

   // AXI handshake state
   logic [15:0] awaddr_q;
   logic aw_have_q, w_have_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // Address helpers; unmapped words answer an error code,
   // ignore writes and read as zero
   function automatic logic [11:0] word_index(input logic [15:0] a);
      return a[13:2];
   endfunction
   function automatic logic is_mapped(input logic [11:0] i);
      return (i >= `IDX_SYNC_CTRL && i <= `IDX_FRAME_CNT) || i == `IDX_SYSREF_CTRL;
   endfunction

   // Write path decode
   // A write fires once both halves are present and no answer is pending
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire aw_now = aw_have_q | aw_take;
   wire w_now = w_have_q | w_take;
   wire [15:0] wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_have_q ? wdata_q : s_axi_wdata;
   wire wr_lane0 = w_have_q ? wstrb_q[0] : s_axi_wstrb[0];
   wire wr_fire = aw_now & w_now & ~s_axi_bvalid;
   wire [11:0] wr_idx = word_index(wr_addr);
   wire wr_ok = wr_fire & is_mapped(wr_idx);
   wire wr_b = wr_ok & wr_lane0;
   wire [7:0] wb = wr_data[7:0];

   // Monitor timing
   // The most negative sample maps to 2^(W-1), which the unsigned magnitude holds
   wire [23:0] period = {period2_q, period1_q, period0_q};
   wire [23:0] period_m1 = period - 24'h000001;
   wire expire = (cnt_q >= period_m1);
   wire sysref_edge = sysref & ~sysref_q;
   wire align = sysref_edge & sync_en_q & sysref_rx_en_q;
   wire [SAMPLE_W-1:0] mag_raw = sample[SAMPLE_W-1] ? -sample : sample;
   wire [19:0] mag = 20'(mag_raw);
   wire [19:0] peak_next = (mag > peak_q) ? mag : peak_q;
   wire window_end = expire & ~align;
   wire next_edge_used = align && sync_mode_q == sigmon_pkg::sync_next_edge;
   wire sync_ctrl_wr = wr_b && wr_idx == `IDX_SYNC_CTRL;
   wire update_req = wr_b && wr_idx == `IDX_STAT_CTRL && wb[`UPDATE_BIT];
   wire [19:0] sel_result = (sel_q == `SEL_PEAK) ? result_q : 20'h00000;

   // Write address/data capture, either order
   // Each half is held here until its partner arrives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 16'h0000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end else begin
            if (aw_take) begin
               aw_have_q <= 1'b1;
               awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
               w_have_q <= 1'b1;
               wdata_q <= s_axi_wdata;
               wstrb_q <= s_axi_wstrb;
            end
         end
      end
   end

   // Ready while nothing held and no response pending
   // Readys are registered, so a request is first taken two edges after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sigmon_pkg::resp_okay;
      end else begin
         s_axi_awready <= ~aw_now & ~s_axi_bvalid & ~wr_fire;
         s_axi_wready <= ~w_now & ~s_axi_bvalid & ~wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(wr_idx) ? sigmon_pkg::resp_okay : sigmon_pkg::resp_slverr;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software-written fields; reserved bits are not stored
   // Period bytes take any value; odd periods are for software to avoid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_mode_q <= 1'b0;
         peak_en_q <= 1'b0;
         period0_q <= `PERIOD0_RST;
         period1_q <= 8'h00;
         period2_q <= 8'h00;
         sel_q <= `SEL_RST;
         sysref_rx_en_q <= 1'b0;
      end else if (wr_b) begin
         case (wr_idx)
            `IDX_SYNC_CTRL: sync_mode_q <= wb[`SYNC_MODE_BIT];
            `IDX_MON_CTRL: peak_en_q <= wb[`PEAK_EN_BIT];
            `IDX_PERIOD0: period0_q <= wb;
            `IDX_PERIOD1: period1_q <= wb;
            `IDX_PERIOD2: period2_q <= wb;
            `IDX_STAT_CTRL: sel_q <= wb[2:0];
            `IDX_SYSREF_CTRL: sysref_rx_en_q <= wb[`SYSREF_RX_EN_BIT];
            default: ;
         endcase
      end
   end

   // Sync enable; the hardware clear in next-edge mode wins over a software
   // write in the same cycle, so later edges stay ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_en_q <= 1'b0;
      end else if (next_edge_used) begin
         sync_en_q <= 1'b0;
      end else if (sync_ctrl_wr) begin
         sync_en_q <= wb[`SYNC_EN_BIT];
      end
   end

   // SYSREF edge detector; resets to the idle low level, so no false edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sysref_q <= 1'b0;
      end else begin
         sysref_q <= sysref;
      end
   end

   // Period counter runs 0 to period-1; alignment restarts it next cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 24'h000000;
      end else if (align || expire) begin
         cnt_q <= 24'h000000;
      end else begin
         cnt_q <= cnt_q + 24'h000001;
      end
   end

   // Tick and frame counter; an expiry swallowed by an alignment counts neither
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_q <= 8'h00;
         period_tick <= 1'b0;
      end else begin
         period_tick <= window_end;
         if (window_end) begin
            frame_q <= frame_q + 8'h01;
         end
      end
   end

   // Running peak; cleared at every boundary so each window stands alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         peak_q <= 20'h00000;
      end else if (align || expire) begin
         peak_q <= 20'h00000;
      end else if (peak_en_q && mag > peak_q) begin
         peak_q <= mag;
      end
   end

   // Completed window result; a disabled detector reports zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_q <= 20'h00000;
      end else if (window_end) begin
         result_q <= peak_en_q ? peak_next : 20'h00000;
      end
   end

   // Status snapshot on software request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= 20'h00000;
      end else if (update_req) begin
         status_q <= sel_result;
      end
   end

   // Read decode; update bit always reads zero since it self-clears
   wire [11:0] rd_idx = word_index(s_axi_araddr);
   logic [7:0] rd_byte;
   always_comb begin
      case (rd_idx)
         `IDX_SYNC_CTRL: rd_byte = {6'h00, sync_mode_q, sync_en_q};
         `IDX_MON_CTRL: rd_byte = {6'h00, peak_en_q, 1'b0};
         `IDX_PERIOD0: rd_byte = period0_q;
         `IDX_PERIOD1: rd_byte = period1_q;
         `IDX_PERIOD2: rd_byte = period2_q;
         `IDX_STAT_CTRL: rd_byte = {5'h00, sel_q};
         `IDX_STATUS0: rd_byte = status_q[7:0];
         `IDX_STATUS1: rd_byte = status_q[15:8];
         `IDX_STATUS2: rd_byte = {4'h0, status_q[19:16]};
         `IDX_FRAME_CNT: rd_byte = frame_q;
         `IDX_SYSREF_CTRL: rd_byte = {7'h00, sysref_rx_en_q};
         default: rd_byte = 8'h00;
      endcase
   end

   // Read channel: one-cycle answer after address accepted
   // Decoded at the handshake edge, so araddr need not stand any longer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= sigmon_pkg::resp_okay;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= is_mapped(rd_idx) ? sigmon_pkg::resp_okay : sigmon_pkg::resp_slverr;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // signal_monitor_peak_sync

/* File: hdl/sigmon_consts.svh */
// Register offsets, field positions, reset values for the signal monitor
`ifndef SIGMON_CONSTS_SVH
`define SIGMON_CONSTS_SVH
// Register indices; byte address is four times the index
`define IDX_SYNC_CTRL 12'h26F
`define IDX_MON_CTRL 12'h270
`define IDX_PERIOD0 12'h271
`define IDX_PERIOD1 12'h272
`define IDX_PERIOD2 12'h273
`define IDX_STAT_CTRL 12'h274
`define IDX_STATUS0 12'h275
`define IDX_STATUS1 12'h276
`define IDX_STATUS2 12'h277
`define IDX_FRAME_CNT 12'h278
`define IDX_SYSREF_CTRL 12'h280
// Field positions
`define SYNC_EN_BIT 0
`define SYNC_MODE_BIT 1
`define PEAK_EN_BIT 1
`define UPDATE_BIT 4
`define SYSREF_RX_EN_BIT 0
// Reset values
`define PERIOD0_RST 8'h80
`define SEL_RST 3'h1
`define SEL_PEAK 3'h1
`endif

/* File: hdl/sigmon_pkg.sv */
// Types shared by the signal monitor design
package sigmon_pkg;
   typedef enum logic [1:0] {
      resp_okay = 2'b00,
      resp_slverr = 2'b10
   } resp_type;
   typedef enum logic [0:0] {
      sync_continuous = 1'b0,
      sync_next_edge = 1'b1
   } sync_mode_type;
endpackage

/* File: dv/sysref_source.sv */
// Timing source model driving single alignment edges
module sysref_source (
   // Clock
   input wire logic aclk,
   // Alignment output
   output logic sysref
);
   timeunit 1ns;
   timeprecision 1ns;
   initial sysref = 1'h0;
   // Lone edges only, so edge spacing never conflicts with the window
   task pulse(input int w);
      @(posedge aclk);
      sysref <= 1'h1;
      repeat (w) @(posedge aclk);
      sysref <= 1'h0;
      repeat (4) @(posedge aclk);
   endtask
endmodule // sysref_source

/* File: dv/signal_monitor_peak_sync_chk.sv */
// Port checker for the signal monitor
module signal_monitor_peak_sync_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Status
   input wire logic period_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
   property p_r_stand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_stand: assert property (p_r_stand) else $error("read answer unstable");
   property p_rdata_byte;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_rdata_byte: assert property (p_rdata_byte) else $error("upper data set");
   property p_tick_pulse;
      period_tick |=> !period_tick;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken early");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken early");
   property p_b_drop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
   property p_r_drop;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_tick: cover property (period_tick);
endmodule // signal_monitor_peak_sync_chk
bind signal_monitor_peak_sync signal_monitor_peak_sync_chk signal_monitor_peak_sync_chk_i (
   .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .period_tick);

/* File: dv/signal_monitor_peak_sync_bench.sv */
// Self-checking bench for the signal monitor
module signal_monitor_peak_sync_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, hold = 0;
   logic awr, wr_r, bv, arr, rv, tick, sysref;
   logic [1:0] br, rr;
   logic [15:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat;
   logic signed [13:0] smp = 0, hv = 0;
   int seed = 31, err_count = 0, checks_done = 0, cyc = 0, ticks = 0, p, m, n;
   logic [33:0] eq[$];
   signal_monitor_peak_sync signal_monitor_peak_sync_i (.aclk, .aresetn,
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .sample(smp), .sysref, .period_tick(tick));
   sysref_source sysref_source_i (.aclk, .sysref);
   initial forever #20 aclk = ~aclk;
   task chk(input logic [33:0] s, e, input string nm);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task finish_test;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Samples, tick tally, result watcher and hang guard
   always @(posedge aclk) begin
      smp <= hold ? hv : 14'($random(seed));
      cyc <= cyc + 1;
      if (tick) begin
         ticks <= ticks + 1;
      end
      if (rv && rry) begin
         chk({rr, rdat}, eq.pop_front(), "read");
      end
      if (bv && bry) begin
         chk({br, 32'h0}, eq.pop_front(), "write");
      end
      if (cyc == 30000) begin
         err_count++;
         finish_test;
      end
   end
   // Answer code goes on the queue before the request leaves
   task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      logic ad;
      logic dd;
      ad = 1'b0;
      dd = 1'b0;
      eq.push_back({r, 32'h0});
      awa <= {2'h0, a, 2'h0};
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (awr && awv) begin
            ad = 1'b1;
            awv <= 1'b0;
         end
         if (wr_r && wv) begin
            dd = 1'b1;
            wv <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bv);
      bry <= 1'b0;
      // One idle edge, so a following call never re-raises bready at once
      @(posedge aclk);
   endtask
   // Expectation goes on the queue before the request leaves
   task rd(input logic [11:0] a, input logic [33:0] e);
      eq.push_back(e);
      ara <= {2'h0, a, 2'h0};
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge aclk); while (!arr);
      arv <= 1'b0;
      do @(posedge aclk); while (!rv);
      rry <= 1'b0;
      @(posedge aclk);
   endtask
   task tk;
      do @(posedge aclk); while (!tick);
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      rd(12'h26F, 34'h0);
      rd(12'h270, 34'h0);
      rd(12'h271, 34'h80);
      rd(12'h274, 34'h1);
      rd(12'h278, 34'h0);
      rd(12'h100, {2'h2, 32'h0});
      wr(12'h100, 8'h5A, 2'h2);
      wr(12'h270, 8'hFF, 2'h0);
      rd(12'h270, 34'h2);
      wr(12'h26F, 8'hFC, 2'h0);
      rd(12'h26F, 34'h0);
      // Even period only; written just after a tick so the count stays below it
      p = 16 + 2 * ($random(seed) & 15);
      tk;
      wr(12'h271, p[7:0], 2'h0);
      tk;
      tk;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!tick);
      chk(n, p, "period");
      wr(12'h270, 8'h00, 2'h0);
      m = 1 + ($random(seed) & 32'h1FFF);
      hv <= 14'(-m);
      hold <= 1;
      repeat (3) tk;
      // The tick seen at this edge is not yet in the tally
      rd(12'h278, 34'((ticks + 1) & 255));
      wr(12'h274, 8'h11, 2'h0);
      rd(12'h275, 34'h0);
      wr(12'h270, 8'h02, 2'h0);
      repeat (3) tk;
      wr(12'h274, 8'h11, 2'h0);
      rd(12'h274, 34'h1);
      rd(12'h275, m[7:0]);
      rd(12'h276, m[15:8]);
      rd(12'h277, 34'h0);
      wr(12'h26F, 8'h03, 2'h0);
      sysref_source_i.pulse(2);
      rd(12'h26F, 34'h3);
      wr(12'h280, 8'h01, 2'h0);
      sysref_source_i.pulse(1);
      rd(12'h26F, 34'h2);
      wr(12'h26F, 8'h01, 2'h0);
      sysref_source_i.pulse(3);
      // Edge is taken one edge into the pulse, which returns six edges later
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!tick);
      chk(n, p - 5, "align");
      rd(12'h26F, 34'h1);
      finish_test;
   end
endmodule // signal_monitor_peak_sync_bench
